// ===== pmt_pkg.sv
package pmt_pkg;

   // ------------------------------------------------------------
   // Power modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PMT_ACTIVE,
      PMT_PSAVE,
      PMT_IDLE,
      PMT_HALT
   } pmt_mode_t;

   // ------------------------------------------------------------
   // Control/status byte layout
   // ------------------------------------------------------------
   localparam int PSAVE_REQ_BIT = 0;
   localparam int FAST_OFF_BIT = 1;
   localparam int IDLE_BIT = 2;
   localparam int HALT_BIT = 3;
   localparam int DEFER_BIT = 5;
   localparam int FSTB_BIT = 6;
   localparam int SSTB_BIT = 7;
   localparam logic [7:0] CSR_RESET = 8'h00;

   // ------------------------------------------------------------
   // Controller register map (APB byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CSR = 8'h00;
   localparam logic [7:0] REG_WAIT = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_NMI = 8'h0C;
   localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

   // ------------------------------------------------------------
   // Sizes and timing
   // ------------------------------------------------------------
   localparam int WAKE_CH = 16;
   // Fast clock divided by (255+1)*2 for the derived slow clock
   localparam int SLOW_DIV = 512;

endpackage : pmt_pkg

// ===== pmt_if.sv
`timescale 1ns/100ps
`default_nettype none

interface pmt_if;
   import pmt_pkg::*;

   // ------------------------------------------------------------
   // CPU to sequencer
   // ------------------------------------------------------------
   logic csr_wr;
   logic [7:0] csr_wdata;
   logic wait_exec;
   logic nmi;

   // ------------------------------------------------------------
   // Sequencer to CPU
   // ------------------------------------------------------------
   logic [7:0] csr_rdata;
   pmt_mode_t mode;

   modport dev (
      input csr_wr,
      input csr_wdata,
      input wait_exec,
      input nmi,
      output csr_rdata,
      output mode
   );

   modport cpu (
      output csr_wr,
      output csr_wdata,
      output wait_exec,
      output nmi,
      input csr_rdata,
      input mode
   );

endinterface : pmt_if

`default_nettype wire

// ===== pmt_cpu_end.sv
`timescale 1ns/100ps
`default_nettype none

module pmt_cpu_end (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link to the sequencer
   pmt_if.cpu link
);
   import pmt_pkg::*;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire setup_done = psel & penable & ~pready;
   wire commit = psel & penable & pready;
   wire hit_csr = paddr == REG_CSR;
   wire hit_wait = paddr == REG_WAIT;
   wire hit_status = paddr == REG_STATUS;
   wire hit_nmi = paddr == REG_NMI;
   wire mapped = hit_csr | hit_wait | hit_status | hit_nmi;
   logic [7:0] last_wdata;
   // Status word gives software the stable flags to poll
   wire [31:0] status_word = {22'h00_0000, link.mode, link.csr_rdata};
   wire [31:0] csr_word = {24'h00_0000, last_wdata};
   wire [31:0] read_mux = hit_status ? status_word :
                          hit_csr ? csr_word : PRDATA_RESET;

   // ------------------------------------------------------------
   // Bus answer: one wait state, data held with pready
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= PRDATA_RESET;
      end else if (clk_en) begin
         pready <= setup_done;
         pslverr <= setup_done & ~mapped;
         prdata <= (setup_done & ~pwrite) ? read_mux : PRDATA_RESET;
      end
   end

   // ------------------------------------------------------------
   // Orders to the sequencer, one-cycle strobes
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.csr_wr <= 1'b0;
         link.csr_wdata <= CSR_RESET;
         link.wait_exec <= 1'b0;
         link.nmi <= 1'b0;
         last_wdata <= CSR_RESET;
      end else if (clk_en) begin
         // Mode bits written first, wait issued by a later order
         link.csr_wr <= commit & pwrite & hit_csr;
         link.wait_exec <= commit & pwrite & hit_wait;
         link.nmi <= commit & pwrite & hit_nmi & pwdata[0];
         if (commit & pwrite & hit_csr) begin
            link.csr_wdata <= pwdata[7:0];
            last_wdata <= pwdata[7:0];
         end
      end
   end

endmodule : pmt_cpu_end

`default_nettype wire

// ===== pmt_dev_end.sv
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Halt needs halt bit then wait
// - Halt from Active, Power Save or Idle
// - Writing power save zero returns Active
// - Power save bit reads one until Active or a wake
// - Software re-enables fast oscillator first
// - Wake-up goes straight to Active
// - Wake sources: NMI or any wake channel
// - Wake clears disable, waits fast stable
// - Stable flags mirror oscillator readiness
// - Switch waits for needed clock stable
// - No crystal: fast stops only in Halt
// - No crystal: wake into fast-clock Active
// - No crystal: Power Save on divided clock
// - Crystal pin low means derive slow clock
// - Byte layout, flags read-only, reset zero
// - Wake clears idle, halt, power save
// - Active to Save/Idle needs slow stable
// - Fast runs in Active, stops in Halt
module pmt_dev_end #(
   parameter int WAKE_CH = pmt_pkg::WAKE_CH,
   parameter int SLOW_DIV = pmt_pkg::SLOW_DIV
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Link to the CPU
   pmt_if.dev link,
   // Oscillator status and crystal pin, asynchronous
   input wire logic fast_osc_good,
   input wire logic slow_osc_good,
   input wire logic slow_crystal_input,
   // Wake-up channels, same clock
   input wire logic [WAKE_CH-1:0] multi_input_wakeup_unit,
   // Clock unit controls
   output logic stop_fast_osc,
   output logic slow_clk_tick
);
   import pmt_pkg::*;

   localparam int DIV_W = (SLOW_DIV > 2) ? $clog2(SLOW_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_DIV - 1);
   localparam logic [DIV_W-1:0] DIV_ZERO = '0;

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   logic [2:0] sync_meta;
   logic [2:0] sync_out;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_meta <= 3'h0;
         sync_out <= 3'h0;
      end else if (clk_en) begin
         sync_meta <= {slow_crystal_input, slow_osc_good, fast_osc_good};
         sync_out <= sync_meta;
      end
   end

   wire fast_stable = sync_out[0];
   wire crystal_present = sync_out[2];
   // Derived slow clock is only as good as the fast clock feeding it
   wire slow_stable = crystal_present ? sync_out[1] : fast_stable;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   pmt_mode_t mode;
   pmt_mode_t target;
   pmt_mode_t next_target;
   pmt_mode_t wait_target;
   logic power_save_request;
   logic fast_osc_disable;
   logic idle_req;
   logic halt_req;
   logic defer_to_wait;
   logic [DIV_W-1:0] div_cnt;

   // ------------------------------------------------------------
   // Event decode
   // ------------------------------------------------------------
   wire wake = link.nmi | (|multi_input_wakeup_unit);
   wire wr = link.csr_wr;
   wire [7:0] wd = link.csr_wdata;
   wire settled = mode == target;
   wire in_low = mode != PMT_ACTIVE;
   wire sw_exit = wr & ~wd[PSAVE_REQ_BIT] & (mode == PMT_PSAVE)
                  & settled;
   wire sw_enter = wr & wd[PSAVE_REQ_BIT] & ~wd[DEFER_BIT]
                   & ~power_save_request & (mode == PMT_ACTIVE) & settled;
   wire wait_go = link.wait_exec & settled;
   wire need_slow = (mode == PMT_ACTIVE)
                    & ((target == PMT_PSAVE) | (target == PMT_IDLE));
   wire need_fast = target == PMT_ACTIVE;
   // Pending switch is held off while its clock is not stable
   wire go = ~settled & ~(need_slow & ~slow_stable)
             & ~(need_fast & ~fast_stable);
   wire into_active = go & (target == PMT_ACTIVE);
   wire into_psave = go & (target == PMT_PSAVE);

   // ------------------------------------------------------------
   // Destination on a wait instruction
   // ------------------------------------------------------------
   always_comb begin
      wait_target = mode;
      case (mode)
         PMT_ACTIVE: begin
            // Halt reachable from Active only with defer-to-wait
            if (defer_to_wait && halt_req) begin
               wait_target = PMT_HALT;
            end else if (defer_to_wait && idle_req) begin
               wait_target = PMT_IDLE;
            end else if (defer_to_wait && power_save_request) begin
               wait_target = PMT_PSAVE;
            end
         end
         PMT_PSAVE: begin
            if (halt_req) begin
               wait_target = PMT_HALT;
            end else if (idle_req) begin
               wait_target = PMT_IDLE;
            end
         end
         PMT_IDLE: begin
            // Both bits set: Idle steps on to Halt
            if (halt_req) begin
               wait_target = PMT_HALT;
            end
         end
         default: begin
            wait_target = mode;
         end
      endcase
   end

   always_comb begin
      next_target = target;
      if (wake && (in_low || !settled)) begin
         next_target = PMT_ACTIVE;
      end else if (sw_exit) begin
         next_target = PMT_ACTIVE;
      end else if (sw_enter) begin
         next_target = PMT_PSAVE;
      end else if (wait_go) begin
         next_target = wait_target;
      end
   end

   // ------------------------------------------------------------
   // Mode machine
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= PMT_ACTIVE;
         target <= PMT_ACTIVE;
      end else if (clk_en) begin
         target <= next_target;
         if (go) begin
            mode <= target;
         end
      end
   end

   // ------------------------------------------------------------
   // Control/status bits
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_save_request <= CSR_RESET[PSAVE_REQ_BIT];
         defer_to_wait <= CSR_RESET[DEFER_BIT];
      end else if (clk_en) begin
         if (wr) begin
            defer_to_wait <= wd[DEFER_BIT];
         end
         // Hardware completion wins over a software write
         if (wake) begin
            power_save_request <= 1'b0;
         end else if (into_psave) begin
            power_save_request <= 1'b1;
         end else if (into_active) begin
            power_save_request <= 1'b0;
         end else if (wr && wd[PSAVE_REQ_BIT] && wd[DEFER_BIT]) begin
            power_save_request <= 1'b1;
         end else if (wr && !wd[PSAVE_REQ_BIT] && mode != PMT_PSAVE) begin
            power_save_request <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_osc_disable <= CSR_RESET[FAST_OFF_BIT];
         idle_req <= CSR_RESET[IDLE_BIT];
         halt_req <= CSR_RESET[HALT_BIT];
      end else if (clk_en) begin
         if (wake) begin
            fast_osc_disable <= 1'b0;
            idle_req <= 1'b0;
            halt_req <= 1'b0;
         end else if (wr) begin
            fast_osc_disable <= wd[FAST_OFF_BIT];
            idle_req <= wd[IDLE_BIT];
            halt_req <= wd[HALT_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // Oscillator control
   // ------------------------------------------------------------
   wire halted = (mode == PMT_HALT) & (target == PMT_HALT);
   // Without a crystal the fast clock feeds the slow one, so keep it
   wire low_fast_off = crystal_present & fast_osc_disable
                       & ((mode == PMT_PSAVE) | (mode == PMT_IDLE));
   wire next_stop_fast = halted | low_fast_off;
   wire div_run = ~crystal_present & fast_stable;
   wire div_wrap = div_cnt == DIV_LAST;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_fast_osc <= 1'b0;
         slow_clk_tick <= 1'b0;
         div_cnt <= DIV_ZERO;
      end else if (clk_en) begin
         stop_fast_osc <= next_stop_fast;
         slow_clk_tick <= div_run & div_wrap;
         if (!div_run || div_wrap) begin
            div_cnt <= DIV_ZERO;
         end else begin
            div_cnt <= div_cnt + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Readback to the CPU
   // ------------------------------------------------------------
   wire [7:0] next_rdata = {slow_stable, fast_stable, defer_to_wait, 1'b0,
                            halt_req, idle_req, fast_osc_disable,
                            power_save_request};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.csr_rdata <= CSR_RESET;
         link.mode <= PMT_ACTIVE;
      end else if (clk_en) begin
         link.csr_rdata <= next_rdata;
         link.mode <= mode;
      end
   end

endmodule : pmt_dev_end

`default_nettype wire

// ===== pmt_link_checker.sv
`timescale 1ns/100ps
`default_nettype none

module pmt_link_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link signals
   input wire logic csr_wr,
   input wire logic [7:0] csr_wdata,
   input wire logic wait_exec,
   input wire logic nmi,
   input wire logic [7:0] csr_rdata,
   input wire pmt_pkg::pmt_mode_t mode
);
   import pmt_pkg::*;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ------------------------------------------------------------
   // Wake-up steps
   // ------------------------------------------------------------
   sequence s_bits_gone;
      ##2 csr_rdata[3:0] == 4'h0;
   endsequence

   sequence s_no_side_step;
      (mode == PMT_ACTIVE || $stable(mode)) [*6];
   endsequence

   chk_rsvd_zero: assert property (
      csr_rdata[4] == 1'b0) else $error("reserved bit set");
   chk_wake_clears: assert property (
      nmi |-> s_bits_gone) else $error("wake left request bits");
   chk_wake_active: assert property (
      nmi && mode != PMT_HALT && !csr_rdata[1] |-> ##[1:6] mode == PMT_ACTIVE)
      else $error("wake did not reach active");
   chk_wake_direct: assert property (
      nmi |-> ##1 s_no_side_step) else $error("wake passed another mode");
   chk_halt_bit: assert property (
      $rose(mode == PMT_HALT) |-> csr_rdata[3])
      else $error("halt without bit");
   chk_halt_from: assert property (
      $rose(mode == PMT_HALT) |-> csr_rdata[5] || $past(mode) != PMT_ACTIVE)
      else $error("halt from active without defer");
   chk_idle_bit: assert property (
      $rose(mode == PMT_IDLE) |-> csr_rdata[2])
      else $error("idle without bit");
   chk_save_from: assert property (
      $rose(mode == PMT_PSAVE) |-> $past(mode) == PMT_ACTIVE)
      else $error("power save entered from low mode");
   chk_strobe_pulse: assert property (
      csr_wr || wait_exec || nmi |=> !(csr_wr || wait_exec || nmi))
      else $error("strobe longer than one cycle");

endmodule : pmt_link_checker

`default_nettype wire

// ===== power_mode_transition_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none

module power_mode_transition_controller_tb;
   import pmt_pkg::*;

   localparam int SD = 4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pe;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic fast_osc_good, slow_osc_good, slow_crystal_input;
   logic [15:0] wake_lines;
   logic stop_fast_osc, slow_clk_tick, clk_en;
   int errors, checked, fcnt, nt, ch, m_csr;
   int seed = 32'h58f0_20c3;

   pmt_if link_if ();

   pmt_cpu_end pmt_cpu_end_inst (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link_if.cpu));

   pmt_dev_end #(.SLOW_DIV(SD)) pmt_dev_end_inst (.pclk(pclk),
      .presetn(presetn), .clk_en(clk_en), .link(link_if.dev),
      .fast_osc_good(fast_osc_good), .slow_osc_good(slow_osc_good),
      .slow_crystal_input(slow_crystal_input),
      .multi_input_wakeup_unit(wake_lines), .stop_fast_osc(stop_fast_osc),
      .slow_clk_tick(slow_clk_tick));

   pmt_link_checker pmt_link_checker_inst (.pclk(pclk), .presetn(presetn),
      .csr_wr(link_if.csr_wr), .csr_wdata(link_if.csr_wdata),
      .wait_exec(link_if.wait_exec), .nmi(link_if.nmi),
      .csr_rdata(link_if.csr_rdata), .mode(link_if.mode));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ------------------------------------------------------------
   // Fast oscillator: slow restart so the stable wait is visible
   // ------------------------------------------------------------
   always @(posedge pclk) begin
      if (stop_fast_osc === 1'b1) begin
         fcnt <= 0;
         fast_osc_good <= 1'b0;
      end else if (fcnt < 30) begin
         fcnt <= fcnt + 1;
      end else begin
         fast_osc_good <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Model and helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] st(input int md, input int fl);
      return 32'((md << 8) | (fl << 6) | m_csr);
   endfunction : st

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      pe = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rv);
   endtask : wr

   // Status reads until the expected value shows, bounded
   task poll(input logic [31:0] exp);
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h08, 32'h0000_0000, rv);
         n++;
      end while (rv !== exp && n < 60);
      chk(rv, exp);
   endtask : poll

   task end_sim;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      end_sim;
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, pe} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      wake_lines = 16'h0000;
      clk_en = 1'b1;
      {fast_osc_good, slow_crystal_input, slow_osc_good} = 3'h6;
      fcnt = 30;
      m_csr = 0;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h10, 32'h0000_0000, rv);
      chk({31'h0, pe}, 32'h0000_0001);
      chk(rv, 32'h0000_0000);
      apb(1'b0, 8'h00, 32'h0000_0000, rv);
      chk(rv, 32'h0000_0000);
      poll(st(0, 1));
      wr(8'h00, 32'h0000_0001);
      repeat (10) @(posedge pclk);
      poll(st(0, 1));
      slow_osc_good <= 1'b1;
      m_csr = 1;
      poll(st(1, 3));
      wr(8'h00, 32'h0000_0003);
      m_csr = 3;
      poll(st(1, 2));
      wr(8'h00, 32'h0000_0001);
      wr(8'h00, 32'h0000_0000);
      m_csr = 1;
      apb(1'b0, 8'h08, 32'h0000_0000, rv);
      chk(rv, st(1, 2));
      m_csr = 0;
      poll(st(0, 3));
      wr(8'h00, 32'h0000_0008);
      wr(8'h04, 32'h0000_0000);
      repeat (6) @(posedge pclk);
      m_csr = 8;
      poll(st(0, 3));
      wr(8'h00, 32'h0000_0028);
      m_csr = 8'h28;
      chk({31'h0, stop_fast_osc}, 32'h0000_0000);
      wr(8'h04, 32'h0000_0000);
      poll(st(3, 2));
      chk({31'h0, stop_fast_osc}, 32'h0000_0001);
      ch = {$random(seed)} % 16;
      wake_lines <= 16'h0001 << ch;
      @(posedge pclk);
      wake_lines <= 16'h0000;
      m_csr = 8'h20;
      apb(1'b0, 8'h08, 32'h0000_0000, rv);
      chk(rv, st(3, 2));
      poll(st(0, 3));
      wr(8'h00, 32'h0000_0024);
      wr(8'h04, 32'h0000_0000);
      m_csr = 8'h24;
      poll(st(2, 3));
      wr(8'h0C, 32'h0000_0001);
      m_csr = 8'h20;
      poll(st(0, 3));
      slow_crystal_input <= 1'b0;
      slow_osc_good <= 1'b0;
      wr(8'h00, 32'h0000_0003);
      m_csr = 3;
      poll(st(1, 3));
      chk({31'h0, stop_fast_osc}, 32'h0000_0000);
      nt = 0;
      repeat (4 * SD) begin
         @(posedge pclk);
         if (slow_clk_tick === 1'b1)
            nt++;
      end
      chk(32'(nt), 32'h0000_0004);
      // Frozen clock enable: a wake must not move the mode
      clk_en <= 1'b0;
      wake_lines <= 16'h0001 << ch;
      repeat (4) @(posedge pclk);
      chk(32'(link_if.mode), 32'(PMT_PSAVE));
      clk_en <= 1'b1;
      wake_lines <= 16'h0000;
      wr(8'h00, 32'h0000_0000);
      m_csr = 0;
      poll(st(0, 3));
      wr(8'h00, 32'h0000_002A);
      wr(8'h04, 32'h0000_0000);
      m_csr = 8'h2A;
      poll(st(3, 0));
      chk({31'h0, stop_fast_osc}, 32'h0000_0001);
      wr(8'h0C, 32'h0000_0001);
      m_csr = 8'h20;
      poll(st(0, 3));
      end_sim;
   end

endmodule : power_mode_transition_controller_tb

`default_nettype wire
